//--- rtl/sdw_pkg.sv
// Function
// - Words are 20-bit two's complement, MSB first
// - Only last 20 bits before strobe fall latch
// - Data sampled on rising bit clock edge
// - Strobe falling edge copies shift to parallel
// - Output updates on fourth clock after fall
// - Halted clock keeps bits until strobe falls
// - Stopped clock: strobe low past next bit
// - Sign selects upper or lower DAC code
// - 7FFFF positive full, 80000 negative full
// - Works with 24-bit slots near 16.9 MHz
package sdw_pkg;
    localparam int WORD_W = 20;
    localparam int CODE_W = 19;
    localparam int SLOT_W = 24;
    localparam int UPD_CLKS = 4;
    localparam int DIV_HALF = 1;
    localparam logic [CODE_W:0] LOWER_IDLE = 20'h80000;
    localparam logic [CODE_W-1:0] CODE_ZERO = 19'h00000;
    localparam logic [2:0] UPD_LAST = 3'h4;
    localparam logic [4:0] SLOT_LAST = 5'h17;
    localparam logic [4:0] STROBE_AT = 5'h14;
    localparam logic [1:0] DIV_LAST = 2'h1;
endpackage

//--- rtl/sdw_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdw_link_if;
    logic bit_clk;
    logic bit_data;
    logic word_latch_strobe;
    modport sender (output bit_clk, output bit_data,
                    output word_latch_strobe);
    modport loader (input bit_clk, input bit_data,
                    input word_latch_strobe);
endinterface
`default_nettype wire

//--- rtl/sdw_sender.sv
`timescale 1ns/10ps
`default_nettype none
module sdw_sender
    import sdw_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 clk_en_i,
    input  wire logic [WORD_W-1:0]    word_i,
    input  wire logic                 word_valid_i,
    output logic                      word_ready_o,
    sdw_link_if.sender                link
);
    import sdw_pkg::*;

    typedef enum logic [1:0] {
        SDW_IDLE = 2'b00,
        SDW_SHIFT = 2'b01
    } sdw_state_t;

    sdw_state_t        state_r;
    logic [1:0]        div_r;
    logic [4:0]        bit_cnt_r;
    logic [SLOT_W-1:0] shift_r;
    logic              clk_r;
    logic              data_r;
    logic              strobe_r;
    logic              ready_r;

    // Fall edge of generated bit clock is where data changes
    wire tick_w   = clk_en_i && (div_r == DIV_LAST);
    wire fall_w   = tick_w && clk_r;
    wire take_w   = (state_r == SDW_IDLE) && word_valid_i && ready_r;
    wire last_w   = (bit_cnt_r == SLOT_LAST);

    // Bit clock divider, free running
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= 2'h0;
            clk_r <= 1'b0;
        end else if (clk_en_i) begin
            div_r <= tick_w ? 2'h0 : div_r + 2'h1;
            if (tick_w) begin
                clk_r <= ~clk_r;
            end
        end
    end

    // Slot sequencer: 20 data bits MSB first, then 4 pad bits
    // Word leads the slot so the strobe can fall right after its LSB
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r   <= SDW_IDLE;
            bit_cnt_r <= 5'h00;
            shift_r   <= '0;
            data_r    <= 1'b0;
            strobe_r  <= 1'b1;
            ready_r   <= 1'b0;
        end else if (clk_en_i) begin
            case (state_r)
                SDW_IDLE: begin
                    ready_r <= ~take_w;
                    if (take_w) begin
                        shift_r   <= {word_i, {(SLOT_W-WORD_W){1'b0}}};
                        bit_cnt_r <= 5'h00;
                        state_r   <= SDW_SHIFT;
                    end
                end
                SDW_SHIFT: begin
                    if (fall_w) begin
                        data_r  <= shift_r[SLOT_W-1];
                        shift_r <= {shift_r[SLOT_W-2:0], 1'b0};
                        // Strobe low across the next slot start
                        if (bit_cnt_r >= STROBE_AT) begin
                            strobe_r <= 1'b0;
                        end else if (|bit_cnt_r) begin
                            strobe_r <= 1'b1;
                        end
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (last_w) begin
                            state_r <= SDW_IDLE;
                        end
                    end
                end
                default: state_r <= SDW_IDLE;
            endcase
        end
    end

    assign link.bit_clk           = clk_r;
    assign link.bit_data          = data_r;
    assign link.word_latch_strobe = strobe_r;
    assign word_ready_o           = ready_r;
endmodule
`default_nettype wire

//--- rtl/sdw_loader.sv
`timescale 1ns/10ps
`default_nettype none
module sdw_loader
    import sdw_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 clk_en_i,
    sdw_link_if.loader                link,
    output logic [CODE_W-1:0]         upper_code_o,
    output logic [CODE_W:0]           lower_code_o,
    output logic                      update_o
);
    import sdw_pkg::*;

    logic [2:0]        clk_s_r;
    logic [2:0]        dat_s_r;
    logic [2:0]        stb_s_r;
    logic              clk_q_r;
    logic              stb_q_r;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] par_r;
    logic              pend_r;
    logic [2:0]        upd_cnt_r;
    logic [CODE_W-1:0] upper_r;
    logic [CODE_W:0]   lower_r;
    logic              update_r;

    // Filtered levels: change counted when stages two and three agree
    wire clk_f_w = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : clk_q_r;
    wire stb_f_w = (stb_s_r[1] == stb_s_r[2]) ? stb_s_r[2] : stb_q_r;
    wire rise_w  = clk_f_w && !clk_q_r;
    wire sfall_w = !stb_f_w && stb_q_r;
    wire sign_w  = par_r[WORD_W-1];
    // Sign magnitude split of latched word
    wire [CODE_W-1:0] upper_w = sign_w ? CODE_ZERO : par_r[CODE_W-1:0];
    wire [CODE_W:0]   lower_w = sign_w ? {1'b0, par_r[CODE_W-1:0]}
                                       : LOWER_IDLE;

    // Three-stage pin synchronisers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_s_r <= 3'h0;
            dat_s_r <= 3'h0;
            stb_s_r <= 3'h7;
            clk_q_r <= 1'b0;
            stb_q_r <= 1'b1;
        end else if (clk_en_i) begin
            clk_s_r <= {clk_s_r[1:0], link.bit_clk};
            dat_s_r <= {dat_s_r[1:0], link.bit_data};
            stb_s_r <= {stb_s_r[1:0], link.word_latch_strobe};
            clk_q_r <= clk_f_w;
            stb_q_r <= stb_f_w;
        end
    end

    // Shift on bit clock rise, keep last 20 bits, any strobe level
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_r <= '0;
        end else if (clk_en_i && rise_w) begin
            shift_r <= {shift_r[WORD_W-2:0], dat_s_r[2]};
        end
    end

    // Strobe fall latches; fourth clock rise after it updates output
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            par_r     <= '0;
            pend_r    <= 1'b0;
            upd_cnt_r <= 3'h0;
        end else if (clk_en_i) begin
            if (sfall_w) begin
                par_r     <= shift_r;
                pend_r    <= 1'b1;
                upd_cnt_r <= 3'h0;
            end else if (pend_r && rise_w) begin
                upd_cnt_r <= upd_cnt_r + 3'h1;
                if (upd_cnt_r + 3'h1 == UPD_LAST) begin
                    pend_r <= 1'b0;
                end
            end
        end
    end

    wire fire_w = pend_r && rise_w && !sfall_w
                  && (upd_cnt_r + 3'h1 == UPD_LAST);

    // Output codes change only on the update edge
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upper_r  <= CODE_ZERO;
            lower_r  <= LOWER_IDLE;
            update_r <= 1'b0;
        end else if (clk_en_i) begin
            update_r <= fire_w;
            if (fire_w) begin
                upper_r <= upper_w;
                lower_r <= lower_w;
            end
        end
    end

    assign upper_code_o = upper_r;
    assign lower_code_o = lower_r;
    assign update_o     = update_r;
endmodule
`default_nettype wire

//--- dv/sdw_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sdw_assertions (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        bit_clk,
    input wire logic        bit_data,
    input wire logic        word_latch_strobe,
    input wire logic [18:0] upper_code_o,
    input wire logic [19:0] lower_code_o,
    input wire logic        update_o
);
    // One clock domain for every check
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Code outputs of the converter pair
    chk_sign_split: assert property (
        update_o |-> upper_code_o == 19'h0 || lower_code_o == 20'h80000)
        else $error("codes not split by sign");
    chk_lower_carry: assert property (
        lower_code_o[19] |-> lower_code_o[18:0] == 19'h0)
        else $error("lower carry with nonzero code");
    chk_update_pulse: assert property (
        update_o |=> !update_o) else $error("update longer than one cycle");
    chk_codes_hold: assert property (
        $changed(lower_code_o) || $changed(upper_code_o) |-> update_o)
        else $error("codes moved without update");
    chk_update_late: assert property (
        $fell(word_latch_strobe) |-> !update_o [*8] ##[9:13] update_o)
        else $error("update not on fourth bit clock");
    // Wire side of the link
    chk_bit_rate: assert property (
        $rose(bit_clk) |-> bit_clk [*2] ##1 !bit_clk)
        else $error("bit clock high phase wrong");
    chk_data_steady: assert property (
        $rose(bit_clk) |-> $stable(bit_data) ##1 $stable(bit_data))
        else $error("data moved at bit clock rise");
    chk_strobe_low: assert property (
        $fell(word_latch_strobe) |-> !word_latch_strobe [*8])
        else $error("strobe released too early");
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sdw_pkg::*;
    logic              ref_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              valid = 1'b0;
    logic              bclk_q = 1'b0;
    logic              strb_q = 1'b1;
    logic              ready, update;
    logic [WORD_W-1:0] word = '0, sent = '0, mon_sh = '0;
    logic [CODE_W-1:0] upper;
    logic [CODE_W:0]   lower;
    int                mismatches = 0, n_compared = 0, cycles = 0;
    sdw_link_if link ();
    sdw_sender u_sdw_sender (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .clk_en_i(1'b1), .word_i(word), .word_valid_i(valid),
        .word_ready_o(ready), .link(link.sender));
    sdw_loader u_sdw_loader (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .clk_en_i(1'b1), .link(link.loader), .upper_code_o(upper),
        .lower_code_o(lower), .update_o(update));
    sdw_assertions u_sdw_assertions (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n), .bit_clk(link.bit_clk),
        .bit_data(link.bit_data), .word_latch_strobe(link.word_latch_strobe),
        .upper_code_o(upper), .lower_code_o(lower), .update_o(update));
    // Reference clock, 40 ns period
    always #20 ref_clk = ~ref_clk;
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [38:0] got, input logic [38:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    // Sign-magnitude split expected for a word
    function automatic logic [38:0] split(input logic [19:0] w);
        return w[19] ? {19'h0, 1'b0, w[18:0]} : {w[18:0], 20'h80000};
    endfunction
    // Wire monitor: last bits shifted before the strobe falls
    always @(posedge ref_clk) begin
        if (link.bit_clk && !bclk_q)
            mon_sh <= {mon_sh[18:0], link.bit_data};
        if (!link.word_latch_strobe && strb_q && reset_n)
            check(39'(mon_sh), 39'(sent));
        bclk_q <= link.bit_clk;
        strb_q <= link.word_latch_strobe;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic send(input logic [19:0] w);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            give_verdict();
        end
        @(posedge ref_clk);
        word <= w;
        valid <= 1'b1;
        sent <= w;
        @(posedge ref_clk);
        valid <= 1'b0;
        n = 0;
        while (update !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
            give_verdict();
        end
        check({upper, lower}, split(w));
    endtask
    // Corner codes first, then random words
    initial begin
        logic [19:0] corner [5];
        corner = '{20'h7ffff, 20'h80000, 20'h00000, 20'hfffff, 20'h00001};
        void'($urandom(32'h99cd));
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 25; i++) begin
            send(i < 5 ? corner[i] : 20'($urandom));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
